// ---- hw/ord_params.svh ----
// Constants of the output rate divider: field positions, reset values, timing.
// Assumes inclusion by the package and design files of this block only.
// Functional notes
// - Divider is coarse times 384 plus fine times adjust
// - Fractional divider rounds down to integer cycles
// - Coarse code bits 15:13 select coarse factor
// - Fine factor follows coarse code table
// - Fine adjust bits 10:0 lengthen the period
// - Rate register moves as exactly 16 bits
// - New rate applies after 16 more periods
// - Ready output low marks a new result
// - Latency is six periods plus phase plus 30us
// - Switch period between samples 16 and 17 differs
// - Channel 2 slot ends zeros, tag, code 10
// - Channel 3 result, zeros, tag, code 11
// - Position tag 000 nearest host, counts upward
// - Each converter yields a 96-bit four-slot frame
// - Unread results are overwritten by the next
`ifndef ORD_PARAMS_SVH
`define ORD_PARAMS_SVH
`define ORD_RATE_WIDTH      16
`define ORD_COARSE_MSB      15
`define ORD_COARSE_LSB      13
`define ORD_FINE_MSB        10
`define ORD_FINE_LSB        0
`define ORD_RATE_RESET      16'h0000
`define ORD_BASE_CYCLES     17'h0_0180
`define ORD_SWITCH_PERIODS  5'h1_0
`define ORD_DIV_WIDTH       17
`define ORD_FRAME_WIDTH     96
`define ORD_CLK_PERIOD_PS   4000
`define ORD_PHASE_STEP_PS   1300000
`define ORD_LAT_FIXED_PS    30000000
`endif

// ---- hw/ord_pkg.sv ----
// Types shared by the output rate divider files.
// Assumes the constants header sits beside this file.
`include "ord_params.svh"
package ord_pkg;
   typedef struct packed {
      logic [2:0]  coarse_rate_code;
      logic [1:0]  reserved;
      logic [10:0] fine_period_adjust;
   } ord_rate_t;

   typedef struct packed {
      logic [15:0] ch0;
      logic [15:0] ch1;
      logic [15:0] ch2;
      logic [15:0] ch3;
   } ord_results_t;

   typedef enum logic {ORD_IDLE, ORD_PENDING} ord_state_t;
endpackage

// ---- hw/ord_period_gen.sv ----
// Output period generator: one tick per output data period.
// Assumes the rate word is stable except when the top swaps it at a tick.
`timescale 1ns/1ps
`include "ord_params.svh"
module ord_period_gen (
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   input  wire ord_pkg::ord_rate_t           activeRate,
   output logic                              periodTick,
   output logic [`ORD_DIV_WIDTH-1:0]         divider
);
   import ord_pkg::*;

   function automatic logic [`ORD_DIV_WIDTH-1:0] calc_divider(input ord_rate_t r);
      logic [7:0] coarse;
      logic [5:0] fine;
      coarse = 8'h01;
      fine   = 6'h01;
      case (r.coarse_rate_code)
         3'h0: begin coarse = 8'h04; fine = 6'h01; end
         3'h1: begin coarse = 8'h80; fine = 6'h20; end
         3'h2: begin coarse = 8'h40; fine = 6'h10; end
         3'h3: begin coarse = 8'h20; fine = 6'h08; end
         3'h4: begin coarse = 8'h10; fine = 6'h04; end
         3'h5: begin coarse = 8'h08; fine = 6'h02; end
         3'h6: begin coarse = 8'h02; fine = 6'h01; end
         default: begin coarse = 8'h01; fine = 6'h01; end
      endcase
      // Integer factors only, so the floor is exact
      calc_divider = ({9'h000, coarse} * `ORD_BASE_CYCLES)
                   + ({11'h000, fine} * {6'h00, r.fine_period_adjust});
   endfunction

   logic [`ORD_DIV_WIDTH-1:0] count;
   wire  logic                atEnd;

   assign divider    = calc_divider(activeRate);
   assign atEnd      = (count >= divider - `ORD_DIV_WIDTH'(1));
   assign periodTick = atEnd;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (atEnd) begin
         count <= '0;
      end else begin
         count <= count + `ORD_DIV_WIDTH'(1);
      end
   end
endmodule

// ---- hw/ord_top.sv ----
// Output rate divider top: rate register, deferred rate switch, result frame,
// ready flag and latency figure. ref_clk is the oscillator input clock.
// Assumes host strobes and straps are asynchronous pins; channel results come
// from converter logic on ref_clk and are sampled at each period tick.
`timescale 1ns/1ps
`include "ord_params.svh"
module ord_top #(
   parameter int LAT_FIXED_CYCLES = `ORD_LAT_FIXED_PS / `ORD_CLK_PERIOD_PS
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic                          rateWrite,
   input  wire logic [`ORD_RATE_WIDTH-1:0]    rateWrData,
   output logic      [`ORD_RATE_WIDTH-1:0]    rateRdData,
   input  wire logic                          frameRead,
   input  wire logic [2:0]                    cascade_position_tag,
   input  wire logic [7:0]                    sample_phase_delay,
   input  wire ord_pkg::ord_results_t         channelResults,
   output logic      [`ORD_FRAME_WIDTH-1:0]   resultFrame,
   output logic                               result_ready_out_n,
   output logic      [23:0]                   latencyCycles,
   output logic                               rateSwitchTick
);
   import ord_pkg::*;

   localparam int PHASE_CYCLES = `ORD_PHASE_STEP_PS / `ORD_CLK_PERIOD_PS;

   // Two-stage synchronisers for host pins and straps
   logic [1:0]  wrSync;
   logic [1:0]  rdSync;
   logic        wrSeen;
   logic        rdSeen;
   logic [15:0] dataMeta;
   logic [15:0] dataSync;
   logic [2:0]  tagMeta;
   logic [2:0]  tagSync;
   logic [7:0]  phaseMeta;
   logic [7:0]  phaseSync;

   // Edge memory sits after the second stage, so no metastable bit reaches it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrSync <= 2'h0;
         wrSeen <= 1'b0;
      end else begin
         wrSync <= {wrSync[0], rateWrite};
         wrSeen <= wrSync[1];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdSync <= 2'h0;
         rdSeen <= 1'b0;
      end else begin
         rdSync <= {rdSync[0], frameRead};
         rdSeen <= rdSync[1];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dataMeta <= 16'h0000;
         dataSync <= 16'h0000;
      end else begin
         dataMeta <= rateWrData;
         dataSync <= dataMeta;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tagMeta <= 3'h0;
         tagSync <= 3'h0;
      end else begin
         tagMeta <= cascade_position_tag;
         tagSync <= tagMeta;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phaseMeta <= 8'h00;
         phaseSync <= 8'h00;
      end else begin
         phaseMeta <= sample_phase_delay;
         phaseSync <= phaseMeta;
      end
   end

   wire logic writeEvent;
   wire logic readEvent;
   assign writeEvent = wrSync[1] & ~wrSeen;
   assign readEvent  = rdSync[1] & ~rdSeen;

   // Programmed word versus the word the divider runs on
   ord_rate_t  rateReg;
   ord_rate_t  activeRate;
   ord_state_t state;
   logic [4:0] switchCount;
   wire  logic periodTick;
   wire  logic [`ORD_DIV_WIDTH-1:0] divider;

   ord_period_gen u_period (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .activeRate (activeRate),
      .periodTick (periodTick),
      .divider    (divider)
   );

   wire logic switchNow;
   assign switchNow = (state == ORD_PENDING) && periodTick
                      && (switchCount == `ORD_SWITCH_PERIODS - 5'h1);
   assign rateRdData = rateReg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rateReg <= `ORD_RATE_RESET;
      end else if (writeEvent) begin
         rateReg <= dataSync;
      end
   end

   // A fresh write restarts the 16-period wait from zero
   ord_state_t next_state;
   logic [4:0] next_switchCount;

   always_comb begin
      next_state       = state;
      next_switchCount = switchCount;
      case (state)
         ORD_IDLE: begin
            if (writeEvent) begin
               next_state       = ORD_PENDING;
               next_switchCount = 5'h00;
            end
         end
         ORD_PENDING: begin
            if (writeEvent) begin
               next_switchCount = 5'h00;
            end else if (switchNow) begin
               next_state = ORD_IDLE;
            end else if (periodTick) begin
               next_switchCount = switchCount + 5'h01;
            end
         end
         default: next_state = ORD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ORD_IDLE;
         switchCount <= 5'h00;
      end else begin
         state       <= next_state;
         switchCount <= next_switchCount;
      end
   end

   // Old rate runs 16 periods, then the new one; swap only on a tick
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         activeRate <= `ORD_RATE_RESET;
      end else if (switchNow && !writeEvent) begin
         activeRate <= rateReg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rateSwitchTick <= 1'b0;
      end else begin
         rateSwitchTick <= switchNow;
      end
   end

   // Frame layout of the 16-bit variant, one 24-bit slot per channel
   function automatic logic [23:0] slot(input logic [15:0] res, input logic [2:0] tag,
                                        input logic [1:0] chCode);
      slot = {res, 3'h0, tag, chCode};
   endfunction

   wire logic [`ORD_FRAME_WIDTH-1:0] nextFrame;
   assign nextFrame = {slot(channelResults.ch0, tagSync, 2'h0),
                       slot(channelResults.ch1, tagSync, 2'h1),
                       slot(channelResults.ch2, tagSync, 2'h2),
                       slot(channelResults.ch3, tagSync, 2'h3)};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         resultFrame <= '0;
      end else if (periodTick) begin
         // Unread frame is simply replaced, no overrun flag
         resultFrame <= nextFrame;
      end
   end

   // Ready goes low with each new frame; a read releases it; new frame wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_ready_out_n <= 1'b1;
      end else if (periodTick) begin
         result_ready_out_n <= 1'b0;
      end else if (readEvent) begin
         result_ready_out_n <= 1'b1;
      end
   end

   // Latency in ref_clk cycles for the active divider and the synchronised phase strap setting
   wire logic [23:0] nextLatency;
   wire logic [23:0] divTerm;
   wire logic [23:0] phaseTerm;
   // Widened before the products: 255 phase steps overflow 16 bits
   assign divTerm     = 24'(divider) * 24'h00_0006;
   assign phaseTerm   = 24'(phaseSync) * 24'(PHASE_CYCLES);
   assign nextLatency = divTerm + phaseTerm + 24'(LAT_FIXED_CYCLES);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         latencyCycles <= 24'h00_0000;
      end else begin
         latencyCycles <= nextLatency;
      end
   end
endmodule

// ---- test/ord_top_asserts.sv ----
// Port checker for ord_top.
// Assumes binding to ord_top; sees its ports only.
`timescale 1ns/1ps
module ord_top_chk #(
   parameter int LAT_FIXED_CYCLES = 10
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        rateWrite,
   input  wire logic        frameRead,
   input  wire logic [15:0] rateRdData,
   input  wire logic [95:0] resultFrame,
   input  wire logic        result_ready_out_n,
   input  wire logic [23:0] latencyCycles,
   input  wire logic        rateSwitchTick
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_tail; !result_ready_out_n |-> resultFrame[31:24] == {3'h0, resultFrame[28:26], 2'h2}
      && resultFrame[7:0] == {3'h0, resultFrame[4:2], 2'h3}; endproperty
   a_tail: assert property (p_tail) else $error("frame tail fields wrong");
   property p_tag; !result_ready_out_n |-> resultFrame[4:2] == resultFrame[76:74]; endproperty
   a_tag: assert property (p_tag) else $error("position tags differ");
   property p_wr; $changed(rateRdData) |-> $past(rateWrite, 2) || $past(rateWrite, 3)
      || $past(rateWrite, 4); endproperty
   a_wr: assert property (p_wr) else $error("rate word changed unasked");
   property p_lat; $fell(result_ready_out_n) |-> latencyCycles >= 2304 + LAT_FIXED_CYCLES; endproperty
   a_lat: assert property (p_lat) else $error("latency too short");
   property p_hold; $fell(result_ready_out_n) && !frameRead |=> !result_ready_out_n [*2]; endproperty
   a_hold: assert property (p_hold) else $error("ready dropped early");
   property p_defer; $rose(rateWrite) |-> !rateSwitchTick [*8]; endproperty
   a_defer: assert property (p_defer) else $error("rate switched at once");
   property p_frame; $changed(resultFrame) |-> !result_ready_out_n; endproperty
   a_frame: assert property (p_frame) else $error("frame changed without ready");
   property p_pulse; rateSwitchTick |=> !rateSwitchTick; endproperty
   a_pulse: assert property (p_pulse) else $error("switch pulse too long");
endmodule
bind ord_top ord_top_chk #(.LAT_FIXED_CYCLES(LAT_FIXED_CYCLES)) u_chk (.ref_clk(ref_clk),
   .rst_n(rst_n), .rateWrite(rateWrite), .frameRead(frameRead), .rateRdData(rateRdData),
   .resultFrame(resultFrame), .result_ready_out_n(result_ready_out_n),
   .latencyCycles(latencyCycles), .rateSwitchTick(rateSwitchTick));

// ---- test/ord_host_model.sv ----
// Host reader: takes every frame, drops the one at a rate switch.
// Assumes ready and switch tick come straight from ord_top.
`timescale 1ns/1ps
module ord_host_model (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic result_ready_out_n,
   input  wire logic rateSwitchTick,
   output logic      frameRead
);
   int nKept;
   int nDropped;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frameRead <= 1'b0;
         nKept     <= 0;
         nDropped  <= 0;
      end else if (!result_ready_out_n && !frameRead) begin
         frameRead <= 1'b1;
         // Old-rate tail sample may be noisy
         if (!rateSwitchTick) nKept <= nKept + 1;
         else nDropped <= nDropped + 1;
      end else if (result_ready_out_n) begin
         frameRead <= 1'b0;
      end
   end
endmodule

// ---- test/tb_ord_top.sv ----
// Bench for ord_top: reset, frame layout, latency, deferred rate change.
// Assumes ord_host_model reads every frame.
`timescale 1ns/1ps
module tb_ord_top;
   import ord_pkg::*;
   localparam int LAT = 10;
   logic         ref_clk    = 1'b0;
   logic         rst_n      = 1'b0;
   logic         rateWrite  = 1'b0;
   logic [15:0]  rateWrData = 16'h0000;
   logic [2:0]   tag        = 3'h5;
   logic [7:0]   phase      = 8'h02;
   ord_results_t res        = '{16'h1234, 16'h8001, 16'h7ffe, 16'ha5c3};
   logic         frameRead, readyN, swTick;
   logic         swSeen     = 1'b0;
   logic [95:0]  frame;
   logic [15:0]  rdData;
   logic [23:0]  lat;
   int           n_mismatch = 0;
   int           num_checks = 0;
   int           n;
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (swTick === 1'b1) swSeen <= 1'b1;
   ord_top #(.LAT_FIXED_CYCLES(LAT)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
      .rateWrite(rateWrite), .rateWrData(rateWrData), .rateRdData(rdData),
      .frameRead(frameRead), .cascade_position_tag(tag), .sample_phase_delay(phase),
      .channelResults(res), .resultFrame(frame), .result_ready_out_n(readyN),
      .latencyCycles(lat), .rateSwitchTick(swTick));
   ord_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .result_ready_out_n(readyN),
      .rateSwitchTick(swTick), .frameRead(frameRead));
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Cycles from the call to the next falling ready, minus one
   task automatic wait_fall(output int cnt);
      logic last;
      cnt  = 0;
      last = readyN;
      @(negedge ref_clk);
      while (!(last === 1'b1 && readyN === 1'b0) && cnt < 4000) begin
         last = readyN;
         cnt++;
         @(negedge ref_clk);
      end
      if (cnt >= 4000) n_mismatch++;
   endtask
   task automatic t_reset;
      repeat (7) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(rdData, 16'h0000);
      chk(readyN, 1'b1);
      chk(frame, 96'h0);
      @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask
   task automatic t_frame;
      wait_fall(n);
      chk(frame, {res.ch0, 3'h0, tag, 2'h0, res.ch1, 3'h0, tag, 2'h1,
                  res.ch2, 3'h0, tag, 2'h2, res.ch3, 3'h0, tag, 2'h3});
      chk(lat, 24'(6 * 1536 + 2 * 325 + LAT));
      wait_fall(n);
      chk(96'(n + 1), 96'(4 * 384));
      @(posedge ref_clk);
      phase <= 8'hff;
      repeat (4) @(negedge ref_clk);
      chk(lat, 24'(6 * 1536 + 255 * 325 + LAT));
   endtask
   task automatic t_rate;
      wait (readyN === 1'b1);
      @(posedge ref_clk);
      rateWrData <= 16'h0040;
      repeat (3) @(posedge ref_clk);
      rateWrite <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rateWrite <= 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(rdData, 16'h0040);
      repeat (15) wait_fall(n);
      chk(swSeen, 1'b0);
      wait_fall(n);
      chk(96'(n + 1), 96'(1536));
      repeat (3) @(negedge ref_clk);
      chk(swSeen, 1'b1);
      chk(96'(host.nDropped), 96'(1));
      wait_fall(n);
      wait_fall(n);
      chk(96'(n + 1), 96'(1536 + 64));
      // Frames 1 to 19 read so far, frame 16 after the write dropped
      chk(96'(host.nKept), 96'(18));
   endtask
   initial begin
      t_reset();
      t_frame();
      t_rate();
      final_report();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end
endmodule
